// *** sfs_core.v ***
/*
 Serial flash command front-end: status read and write, write enable
 handling and the single, dual and quad output reads plus dual I/O read.
 Assumes the serial pins come from outside this clock domain and that
 the system clock is several times faster than the serial clock.
*/
//
// Overview of operation
// - opcodes 05h and 35h read 8-bit status
// - status shifted out MSB first, falling edges
// - status read allowed even while busy
// - status repeats until chip select rises
// - 01h writes only bits 7:2 and 14:8
// - non-volatile lock bits never return to zero
// - non-volatile write needs write enable latch
// - after 50h write volatile copy, OTP kept
// - write only after exactly 8 or 16 bits
// - one-byte write clears complement and quad
// - non-volatile write: busy for tw, latch cleared
// - volatile write applied at once, busy stays 0
// - power-up reloads non-volatile status values
// - all status bits default to zero
// - 03h plus 24-bit address, sampled rising edge
// - data MSB first, address increments, streams
// - reads ignored while busy
// - 0Bh adds eight dummy clocks, output undefined
// - 3Bh same framing, data on two lines
// - 6Bh only with quad enable, four lines
// - BBh address two bits per clock
// - dual data: odd bits line one, even zero
// - 06h sets the write enable latch unless busy
`timescale 1ns/1ns
`include "sfs_defs.vh"
module sfs_core #(
   parameter ADDR_W = 20,
   parameter [23:0] TW_CYCLES = `SFS_TW_CYCLES
) (
   input wire clk,
   input wire sys_rst,
   input wire spiCsN,
   input wire spiClk,
   input wire [3:0] ioIn,
   output reg [3:0] ioOut,
   output reg [3:0] ioOe,
   input wire extBusy,
   input wire suspendFlag,
   input wire memWrEn,
   input wire [ADDR_W-1:0] memWrAddr,
   input wire [7:0] memWrData,
   output wire writeBusy,
   output wire writeEnableLatch,
   output wire quadEnable
);
   localparam ST_CMD = 7'b0000001;
   localparam ST_ADDR = 7'b0000010;
   localparam ST_DUMMY = 7'b0000100;
   localparam ST_DATA = 7'b0001000;
   localparam ST_STAT = 7'b0010000;
   localparam ST_WRSR = 7'b0100000;
   localparam ST_SKIP = 7'b1000000;

   wire [5:0] pinS;
   wire csS;
   wire sclkS;
   wire [3:0] ioS;
   reg csPrev;
   reg sclkPrev;
   reg [6:0] state;
   reg [5:0] cnt;
   reg [7:0] op;
   reg [7:0] rdOp;
   reg [2:0] laneW;
   reg [23:0] addr;
   reg [7:0] shReg;
   reg [3:0] outCnt;
   reg srSel;
   reg [15:0] wrData;
   reg [14:0] curSr;
   reg [14:0] nvSr;
   reg write_enable_latch;
   reg volEn;
   reg nvBusy;
   reg [23:0] twCnt;
   wire [7:0] memData;
   wire busy;
   wire rise;
   wire fall;
   wire csRise;
   wire [7:0] sr1;
   wire [7:0] sr2;
   wire [7:0] curByte;
   wire [7:0] nxtOp;
   wire [3:0] nxtCnt;
   wire wrOk;

   // non-volatile cells survive sys_rst; factory state is all zero
   initial begin
      nvSr = `SFS_SR_RESET;
   end

   sfs_sync #(
      .W(6)
   ) uSync (
      .clk(clk),
      .d({spiCsN, spiClk, ioIn}),
      .q(pinS)
   );

   sfs_mem #(
      .AW(ADDR_W)
   ) uMem (
      .clk(clk),
      .wrEn(memWrEn),
      .wrAddr(memWrAddr),
      .wrData(memWrData),
      .rdAddr(addr[ADDR_W-1:0]),
      .rdData(memData)
   );

   // merge a status write into the old value, keeping read-only bits
   function [14:0] srMerge(input [14:0] old, input [15:0] d,
      input two, input vol);
      reg [7:0] b1;
      reg [14:0] n;
      begin
         b1 = two ? d[15:8] : d[7:0];
         n = old;
         n[`SFS_SR1_WR_HI:`SFS_SR1_WR_LO] =
            b1[`SFS_SR1_WR_HI:`SFS_SR1_WR_LO];
         if (two) begin
            n[14:8] = d[6:0];
         end else begin
            n[`SFS_SR2_CMP] = 1'b0;
            n[`SFS_SR2_QE] = 1'b0;
         end
         n[`SFS_SR2_LB_HI:`SFS_SR2_LB_LO] =
            n[`SFS_SR2_LB_HI:`SFS_SR2_LB_LO] |
            old[`SFS_SR2_LB_HI:`SFS_SR2_LB_LO];
         if (vol) begin
            n[`SFS_SR2_STATUS_PROTECT_HIGH] = n[`SFS_SR2_STATUS_PROTECT_HIGH] |
               old[`SFS_SR2_STATUS_PROTECT_HIGH];
         end
         srMerge = n;
      end
   endfunction

   // clocks per byte for a lane width of one, two or four lines
   function [3:0] perByte(input [2:0] w);
      begin
         case (w)
            3'h2: perByte = 4'h4;
            3'h4: perByte = 4'h2;
            default: perByte = 4'h8;
         endcase
      end
   endfunction

   assign csS = pinS[5];
   assign sclkS = pinS[4];
   assign ioS = pinS[3:0];
   assign rise = sclkS & ~sclkPrev & ~csS;
   assign fall = ~sclkS & sclkPrev & ~csS;
   assign csRise = csS & ~csPrev;
   assign busy = nvBusy | extBusy;
   assign sr1 = {curSr[7:2], write_enable_latch, busy};
   assign sr2 = {suspendFlag, curSr[14:8]};
   assign nxtOp = {op[6:0], ioS[0]};
   assign curByte = (outCnt != 4'h0) ? shReg :
      (state == ST_STAT) ? (srSel ? sr2 : sr1) : memData;
   assign nxtCnt = ((outCnt == 4'h0) ? perByte(laneW) : outCnt) - 4'h1;
   assign wrOk = (cnt == `SFS_WR_ONE) | (cnt == `SFS_WR_TWO);
   assign writeBusy = nvBusy;
   assign writeEnableLatch = write_enable_latch;
   assign quadEnable = curSr[`SFS_SR2_QE];

   always @(posedge clk) begin
      if (sys_rst) begin
         csPrev <= 1'b1;
         sclkPrev <= 1'b0;
         state <= ST_CMD;
         cnt <= 6'h00;
         op <= 8'h00;
         rdOp <= 8'h00;
         laneW <= 3'h1;
         addr <= 24'h000000;
         shReg <= 8'h00;
         outCnt <= 4'h0;
         srSel <= 1'b0;
         wrData <= 16'h0000;
         curSr <= nvSr;
         write_enable_latch <= 1'b0;
         volEn <= 1'b0;
         nvBusy <= 1'b0;
         twCnt <= 24'h000000;
         ioOut <= 4'h0;
         ioOe <= 4'h0;
      end else begin
         csPrev <= csS;
         sclkPrev <= sclkS;
         if (nvBusy) begin
            twCnt <= twCnt - 24'h000001;
            if (twCnt == 24'h000001) begin
               nvBusy <= 1'b0;
               write_enable_latch <= 1'b0;
            end
         end
         if (csS) begin
            state <= ST_CMD;
            cnt <= 6'h00;
            outCnt <= 4'h0;
            ioOe <= 4'h0;
         end
         // the write only takes effect at the chip select rise
         if (csRise && state == ST_WRSR && wrOk) begin
            if (write_enable_latch) begin
               nvSr <= srMerge(nvSr, wrData, cnt == `SFS_WR_TWO,
                  1'b0);
               curSr <= srMerge(nvSr, wrData, cnt == `SFS_WR_TWO, 1'b0);
               nvBusy <= 1'b1;
               twCnt <= TW_CYCLES;
            end else if (volEn) begin
               curSr <= srMerge(curSr, wrData, cnt == `SFS_WR_TWO,
                  1'b1);
               volEn <= 1'b0;
            end
         end
         if (rise) begin
            case (state)
               ST_CMD: begin
                  op <= nxtOp;
                  cnt <= cnt + 6'h01;
                  if (cnt == `SFS_OP_LAST) begin
                     cnt <= 6'h00;
                     rdOp <= nxtOp;
                     laneW <= 3'h1;
                     state <= ST_SKIP;
                     case (nxtOp)
                        `SFS_OP_RDSR1: begin
                           state <= ST_STAT;
                           srSel <= 1'b0;
                        end
                        `SFS_OP_RDSR2: begin
                           state <= ST_STAT;
                           srSel <= 1'b1;
                        end
                        `SFS_OP_WREN: begin
                           if (!busy) begin
                              write_enable_latch <= 1'b1;
                           end
                        end
                        `SFS_OP_VWREN: begin
                           if (!busy) begin
                              volEn <= 1'b1;
                           end
                        end
                        `SFS_OP_WRDI: begin
                           if (!busy) begin
                              write_enable_latch <= 1'b0;
                              volEn <= 1'b0;
                           end
                        end
                        `SFS_OP_WRSR: begin
                           if (!busy) begin
                              state <= ST_WRSR;
                           end
                           wrData <= 16'h0000;
                        end
                        `SFS_OP_READ, `SFS_OP_FAST: begin
                           if (!busy) begin
                              state <= ST_ADDR;
                           end
                        end
                        `SFS_OP_DOUT, `SFS_OP_DIO: begin
                           laneW <= 3'h2;
                           if (!busy) begin
                              state <= ST_ADDR;
                           end
                        end
                        `SFS_OP_QOUT: begin
                           laneW <= 3'h4;
                           if (!busy && curSr[`SFS_SR2_QE]) begin
                              state <= ST_ADDR;
                           end
                        end
                        default: begin
                           state <= ST_SKIP;
                        end
                     endcase
                  end
               end
               ST_ADDR: begin
                  cnt <= cnt + 6'h01;
                  if (rdOp == `SFS_OP_DIO) begin
                     addr <= {addr[21:0], ioS[1:0]};
                  end else begin
                     addr <= {addr[22:0], ioS[0]};
                  end
                  if ((rdOp == `SFS_OP_DIO && cnt == `SFS_ADDR_LAST2) ||
                     (rdOp != `SFS_OP_DIO && cnt == `SFS_ADDR_LAST1)) begin
                     cnt <= 6'h00;
                     state <= (rdOp == `SFS_OP_READ) ? ST_DATA : ST_DUMMY;
                  end
               end
               ST_DUMMY: begin
                  // mode bits of the dual I/O read are taken and ignored
                  cnt <= cnt + 6'h01;
                  if ((rdOp == `SFS_OP_DIO && cnt == `SFS_MODE_LAST2) ||
                     (rdOp != `SFS_OP_DIO &&
                     cnt == `SFS_DUMMY_LAST)) begin
                     cnt <= 6'h00;
                     state <= ST_DATA;
                  end
               end
               ST_WRSR: begin
                  wrData <= {wrData[14:0], ioS[0]};
                  // saturate so an overlong write can never match
                  if (cnt != `SFS_WR_CAP) begin
                     cnt <= cnt + 6'h01;
                  end
               end
               default: begin
                  cnt <= cnt;
               end
            endcase
         end
         if (fall && (state == ST_DATA || state == ST_STAT)) begin
            // lines are only driven from the first data clock onward
            case (laneW)
               3'h2: begin
                  ioOut <= {2'b00, curByte[7:6]};
                  ioOe <= 4'h3;
               end
               3'h4: begin
                  ioOut <= curByte[7:4];
                  ioOe <= 4'hF;
               end
               default: begin
                  ioOut <= {2'b00, curByte[7], 1'b0};
                  ioOe <= 4'h2;
               end
            endcase
            shReg <= curByte << laneW;
            outCnt <= nxtCnt;
            if (nxtCnt == 4'h0 && state == ST_DATA) begin
               addr <= addr + 24'h000001;
            end
         end
      end
   end
endmodule

// *** sfs_defs.vh ***
/*
 Constants for the serial flash status and read command front-end:
 opcodes, status bit positions, counts and timing.
 Assumes it is included by bare name from the design files.
*/
`ifndef SFS_DEFS_VH
`define SFS_DEFS_VH

`define SFS_OP_WRSR 8'h01
`define SFS_OP_READ 8'h03
`define SFS_OP_WRDI 8'h04
`define SFS_OP_RDSR1 8'h05
`define SFS_OP_WREN 8'h06
`define SFS_OP_FAST 8'h0B
`define SFS_OP_RDSR2 8'h35
`define SFS_OP_DOUT 8'h3B
`define SFS_OP_VWREN 8'h50
`define SFS_OP_QOUT 8'h6B
`define SFS_OP_DIO 8'hBB

// status word bit positions (14:8 holds bits 6:0 of the second status byte)
`define SFS_SR1_WR_HI 7
`define SFS_SR1_WR_LO 2
`define SFS_SR2_STATUS_PROTECT_HIGH 8
`define SFS_SR2_QE 9
`define SFS_SR2_LB_LO 11
`define SFS_SR2_LB_HI 13
`define SFS_SR2_CMP 14
`define SFS_SR_RESET 15'h0000

// bit and clock counts of the framing
`define SFS_OP_LAST 6'h07
`define SFS_ADDR_LAST1 6'h17
`define SFS_ADDR_LAST2 6'h0B
`define SFS_DUMMY_LAST 6'h07
`define SFS_MODE_LAST2 6'h03
`define SFS_WR_ONE 6'h08
`define SFS_WR_TWO 6'h10
`define SFS_WR_CAP 6'h11

// self-timed status write cycle
`define SFS_CLK_MHZ 50
`define SFS_TW_US 10000
`define SFS_TVOL_NS 50
// product of the clock rate and write time above, sized for the cycle counter
`define SFS_TW_CYCLES 24'h07A120

`endif

// *** sfs_sync.v ***
/*
 Two-stage synchroniser for a bundle of independent level inputs.
 Assumes each bit is a level; no bundle coherence is promised.
*/
`timescale 1ns/1ns
module sfs_sync #(
   parameter W = 6
) (
   input wire clk,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta;

   always @(posedge clk) begin
      meta <= d;
      q <= meta;
   end
endmodule

// *** sfs_mem.v ***
/*
 Byte-wide flash array model with a registered read port and a
 load port for initial contents.
 Assumes program and erase engines live elsewhere and use the load port.
*/
`timescale 1ns/1ns
module sfs_mem #(
   parameter AW = 20
) (
   input wire clk,
   input wire wrEn,
   input wire [AW-1:0] wrAddr,
   input wire [7:0] wrData,
   input wire [AW-1:0] rdAddr,
   output reg [7:0] rdData
);
   reg [7:0] mem [0:(1<<AW)-1];

   always @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule

// *** sfs_core_checker.sv ***
/*
 Port checker of the flash command front-end: reset state, output
 timing, busy cycle length, write enable latch and refusals.
 Assumes it is bound to sfs_core and the serial clock is slow.
*/
`timescale 1ns/1ns
module sfs_core_checker #(
   parameter [23:0] TW_CYCLES = 24'h07A120
) (
   input wire clk,
   input wire sys_rst,
   input wire spiCsN,
   input wire spiClk,
   input wire [3:0] ioOut,
   input wire [3:0] ioOe,
   input wire extBusy,
   input wire writeBusy,
   input wire writeEnableLatch,
   input wire quadEnable
);
   reg [23:0] busyCnt;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // counts the cycles of one busy period
   always @(posedge clk) begin
      if (sys_rst || !writeBusy) begin
         busyCnt <= 24'h000000;
      end else begin
         busyCnt <= busyCnt + 24'h000001;
      end
   end
   rst_state_a: assert property (
      $fell(sys_rst) |-> ioOe == 4'h0 && !writeBusy && !writeEnableLatch)
      else $error("outputs not idle after reset");
   cs_idle_a: assert property (
      spiCsN [*5] |-> ioOe == 4'h0)
      else $error("lines driven while deselected");
   out_timing_a: assert property (
      ioOe != 4'h0 && $changed(ioOut) |-> !spiClk && !$past(spiClk))
      else $error("output changed outside a low serial clock");
   busy_len_a: assert property (
      $fell(writeBusy) |-> busyCnt == TW_CYCLES)
      else $error("busy period length wrong");
   wel_clear_a: assert property (
      $fell(writeBusy) |-> !writeEnableLatch)
      else $error("latch not cleared at end of busy");
   busy_cause_a: assert property (
      $rose(writeBusy) |-> writeEnableLatch && spiCsN)
      else $error("busy started without latch or deselect");
   wel_set_a: assert property (
      $rose(writeEnableLatch) |-> !spiCsN && !writeBusy && !extBusy)
      else $error("latch set outside a frame or while busy");
   oe_shape_a: assert property (
      ioOe == 4'h0 || ioOe == 4'h2 || ioOe == 4'h3 || ioOe == 4'hF)
      else $error("illegal enable pattern");
   quad_gate_a: assert property (
      ioOe == 4'hF |-> quadEnable)
      else $error("four lines driven without quad enable");
   busy_refuse_a: assert property (
      (extBusy || writeBusy) && ioOe != 4'h0 |-> ioOe == 4'h2)
      else $error("data driven while busy");
endmodule
bind sfs_core sfs_core_checker #(.TW_CYCLES(TW_CYCLES)) chk (
   .clk(clk), .sys_rst(sys_rst), .spiCsN(spiCsN), .spiClk(spiClk),
   .ioOut(ioOut), .ioOe(ioOe), .extBusy(extBusy), .writeBusy(writeBusy),
   .writeEnableLatch(writeEnableLatch), .quadEnable(quadEnable));

// *** sfs_host_model.sv ***
/*
 Host controller model: mode 0 frames with an 8-clock serial period.
 Assumes the bench resolves the shared lines into ioWire.
*/
`timescale 1ns/1ns
module sfs_host_model (
   input wire clk,
   input wire [3:0] ioWire,
   output reg spiCsN,
   output reg spiClk,
   output reg [3:0] hostDrv,
   output reg [3:0] hostOe
);
   initial begin
      spiCsN = 1'b1;
      spiClk = 1'b0;
      hostDrv = 4'h0;
      hostOe = 4'h1;
   end
   task automatic half;
      repeat (4) @(negedge clk);
   endtask
   // data set while the clock is low, taken by the device at the rise
   task automatic bitOut(input [1:0] v, input rel);
      hostDrv[1:0] = v;
      half;
      spiClk = 1'b1;
      half;
      if (rel) begin
         hostOe = 4'h0;
      end
      spiClk = 1'b0;
   endtask
   task automatic xfer(input [7:0] op, input [31:0] tx, input int ntx,
      input int ltx, input int nrx, input int lrx, output logic [63:0] rx);
      int i;
      rx = 64'h0;
      hostOe = (ltx == 2) ? 4'h3 : 4'h1;
      spiCsN = 1'b0;
      half;
      for (i = 0; i < 8; i++) begin
         bitOut({1'b0, op[7 - i]}, ntx == 0 && i == 7 && lrx > 1);
      end
      for (i = 0; i < ntx; i = i + ltx) begin
         bitOut(ltx == 2 ? tx[ntx - 1 - i -: 2] : {1'b0, tx[ntx - 1 - i]},
            i + ltx >= ntx && lrx > 1);
      end
      for (i = 0; i < nrx; i = i + lrx) begin
         half;
         rx = (rx << lrx) | 64'(lrx == 1 ? {3'h0, ioWire[1]} :
            lrx == 2 ? {2'h0, ioWire[1:0]} : ioWire);
         spiClk = 1'b1;
         half;
         spiClk = 1'b0;
      end
      half;
      spiCsN = 1'b1;
      hostOe = 4'h1;
      repeat (6) @(negedge clk);
   endtask
endmodule

// *** tb_serial_flash_status_and_read_cmds.sv ***
/*
 Self-checking bench of the flash command front-end.
 Assumes the host model drives all serial pins.
*/
`timescale 1ns/1ns
`include "sfs_defs.vh"
`define CHECK_EQ(got, exp) \
   begin \
      nTests++; \
      if ((got) !== (exp)) begin \
         errTotal++; \
         $display("Error at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module tb_serial_flash_status_and_read_cmds;
   // short busy cycle keeps the run brief yet longer than one status poll
   localparam [23:0] TW = 24'h000190;
   localparam [39:0] OPS = {`SFS_OP_READ, `SFS_OP_FAST, `SFS_OP_DOUT,
      `SFS_OP_QOUT, `SFS_OP_DIO};
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg extBusy = 1'b0;
   reg suspendFlag = 1'b1;
   reg memWrEn = 1'b0;
   reg [19:0] memWrAddr = 20'h00000;
   reg [7:0] memWrData = 8'h00;
   reg oeSeen = 1'b0;
   reg [14:0] live = 15'h0000;
   reg [14:0] nv = 15'h0000;
   reg [7:0] mv [0:7];
   reg [19:0] base;
   reg [63:0] rx;
   reg [7:0] b1;
   reg [7:0] b2;
   wire spiCsN, spiClk, writeBusy, writeEnableLatch, quadEnable;
   wire [3:0] hostDrv, hostOe, ioOut, ioOe, ioWire;
   int errTotal = 0;
   int nTests = 0;
   int i;
   int off;
   always #10 clk = ~clk;
   // undriven lines show the inverse of the host's last value
   assign ioWire = (ioOe & ioOut) | (~ioOe & hostOe & hostDrv) |
      (~ioOe & ~hostOe & ~hostDrv);
   always @(posedge clk) if (ioOe !== 4'h0) oeSeen <= 1'b1;
   sfs_core #(.ADDR_W(20), .TW_CYCLES(TW)) DUT (.clk(clk), .sys_rst(rst),
      .spiCsN(spiCsN), .spiClk(spiClk), .ioIn(ioWire), .ioOut(ioOut),
      .ioOe(ioOe), .extBusy(extBusy), .suspendFlag(suspendFlag),
      .memWrEn(memWrEn), .memWrAddr(memWrAddr), .memWrData(memWrData),
      .writeBusy(writeBusy), .writeEnableLatch(writeEnableLatch),
      .quadEnable(quadEnable));
   sfs_host_model host (.clk(clk), .ioWire(ioWire), .spiCsN(spiCsN),
      .spiClk(spiClk), .hostDrv(hostDrv), .hostOe(hostOe));
   function [7:0] sr1(input [14:0] s, input w, input b);
      sr1 = {s[7:2], w, b};
   endfunction
   function [7:0] sr2(input [14:0] s);
      sr2 = {suspendFlag, s[14:8]};
   endfunction
   function [14:0] wr(input [14:0] c, input [7:0] x, input [7:0] y,
      input two, input vol);
      begin
         wr = c;
         wr[7:2] = x[7:2];
         if (two) begin
            wr[14:8] = y[6:0];
            wr[13:11] = y[5:3] | c[13:11];
            if (vol) begin
               wr[8] = y[0] | c[8];
            end
         end else begin
            wr[14] = 1'b0;
            wr[9] = 1'b0;
         end
      end
   endfunction
   task testDone;
      $display("checks %0d, errors %0d", nTests, errTotal);
      if (errTotal == 0 && nTests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task cmd(input [7:0] op, input int n);
      host.xfer(op, 32'h0, 0, 1, n, 1, rx);
   endtask
   task wrsr(input int n);
      host.xfer(`SFS_OP_WRSR, {16'h0, b1, b2} >> (16 - n), n, 1, 0, 1, rx);
   endtask
   task waitIdle;
      for (i = 0; i < 1000 && writeBusy !== 1'b0; i++) @(negedge clk);
      if (i == 1000) begin
         errTotal++;
         testDone;
      end
   endtask
   initial begin
      #1000000;
      errTotal++;
      testDone;
   end
   initial begin
      void'($urandom(62624));
      repeat (5) @(negedge clk);
      rst = 1'b0;
      base = $urandom & 20'hFFFF0;
      for (i = 0; i < 8; i++) begin
         mv[i] = $urandom;
         memWrAddr = base + 20'(i);
         memWrData = mv[i];
         memWrEn = 1'b1;
         @(negedge clk);
      end
      memWrEn = 1'b0;
      repeat (4) @(negedge clk);
      cmd(`SFS_OP_RDSR1, 16);
      `CHECK_EQ(rx[15:0], {2{sr1(live, 1'b0, 1'b0)}});
      cmd(`SFS_OP_RDSR2, 8);
      `CHECK_EQ(rx[7:0], sr2(live));
      oeSeen = 1'b0;
      host.xfer(8'hA5, 32'h0000FFFF, 16, 1, 0, 1, rx);
      `CHECK_EQ(oeSeen, 1'b0);
      b1 = $urandom;
      b2 = $urandom;
      wrsr(16);
      cmd(`SFS_OP_WREN, 0);
      `CHECK_EQ(writeEnableLatch, 1'b1);
      wrsr(12);
      cmd(`SFS_OP_RDSR2, 8);
      `CHECK_EQ(rx[7:0], sr2(live));
      b2[1] = 1'b1;
      // lock and protect bits set here so the volatile write below tries
      // to clear them
      b2[0] = 1'b1;
      b2[3] = 1'b1;
      cmd(`SFS_OP_WREN, 0);
      wrsr(16);
      cmd(`SFS_OP_RDSR1, 8);
      `CHECK_EQ(rx[1:0], 2'h3);
      waitIdle;
      `CHECK_EQ(writeEnableLatch, 1'b0);
      nv = wr(nv, b1, b2, 1'b1, 1'b0);
      live = nv;
      cmd(`SFS_OP_RDSR1, 16);
      `CHECK_EQ(rx[15:0], {2{sr1(live, 1'b0, 1'b0)}});
      cmd(`SFS_OP_RDSR2, 8);
      `CHECK_EQ(rx[7:0], sr2(live));
      for (i = 0; i < 5; i++) begin
         off = $urandom_range(0, 4);
         host.xfer(OPS[39 - 8 * i -: 8], i == 0 ? {12'h0, base + 20'(off)} :
            {4'h0, base + 20'(off), 8'h00}, i == 0 ? 24 : 32, i == 4 ? 2 : 1,
            32, i == 3 ? 4 : (i == 2 || i == 4) ? 2 : 1, rx);
         `CHECK_EQ(rx[31:0], {mv[off], mv[off + 1], mv[off + 2],
            mv[off + 3]});
      end
      extBusy = 1'b1;
      oeSeen = 1'b0;
      host.xfer(`SFS_OP_READ, {12'h0, base}, 24, 1, 16, 1, rx);
      `CHECK_EQ(oeSeen, 1'b0);
      cmd(`SFS_OP_RDSR1, 8);
      `CHECK_EQ(rx[7:0], sr1(live, 1'b0, 1'b1));
      extBusy = 1'b0;
      suspendFlag = 1'b0;
      b1 = $urandom;
      b2 = $urandom;
      b2[1] = 1'b0;
      b2[0] = 1'b0;
      b2[3] = 1'b0;
      cmd(`SFS_OP_VWREN, 0);
      wrsr(16);
      live = wr(live, b1, b2, 1'b1, 1'b1);
      `CHECK_EQ(writeBusy, 1'b0);
      cmd(`SFS_OP_RDSR2, 8);
      `CHECK_EQ(rx[7:0], sr2(live));
      oeSeen = 1'b0;
      host.xfer(`SFS_OP_QOUT, {4'h0, base, 8'h00}, 32, 1, 8, 4, rx);
      `CHECK_EQ(oeSeen, 1'b0);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      live = nv;
      cmd(`SFS_OP_RDSR2, 8);
      `CHECK_EQ(rx[7:0], sr2(live));
      `CHECK_EQ(quadEnable, nv[9]);
      cmd(`SFS_OP_WREN, 0);
      wrsr(8);
      waitIdle;
      nv = wr(nv, b1, b2, 1'b0, 1'b0);
      live = nv;
      cmd(`SFS_OP_RDSR2, 8);
      `CHECK_EQ(rx[7:0], sr2(live));
      `CHECK_EQ(quadEnable, 1'b0);
      testDone;
   end
endmodule
